// ==== design/ost_pkg.sv ====
// ost_pkg: constants, command codes, states and carriers for the output sequencer.
// assumes a single core clock at 125 MHz and command-code register access.
package ost_pkg;

  // command codes of the sequencing registers
  localparam logic [7:0] CMD_PGOOD_ASSERT    = 8'h5E;
  localparam logic [7:0] CMD_PGOOD_DEASSERT  = 8'h5F;
  localparam logic [7:0] CMD_TURN_ON_WAIT    = 8'h60;
  localparam logic [7:0] CMD_TURN_ON_RAMP    = 8'h61;
  localparam logic [7:0] CMD_PWR_UP_LIMIT    = 8'h62;
  localparam logic [7:0] CMD_PWR_UP_ACTION   = 8'h63;
  localparam logic [7:0] CMD_TURN_OFF_WAIT   = 8'h64;
  localparam logic [7:0] CMD_TURN_OFF_RAMP   = 8'h65;
  localparam logic [7:0] CMD_PWR_DOWN_LIMIT  = 8'h66;

  // reset values of the programmable words
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [7:0]  RESET_BYTE = 8'h00;

  // response codes, bits 7:6 of the action byte
  localparam logic [1:0] RESP_IGNORE  = 2'h0;
  localparam logic [1:0] RESP_DELAYED = 2'h1;
  localparam logic [1:0] RESP_DISABLE = 2'h2;
  localparam logic [1:0] RESP_LATCH   = 2'h3;

  // retry codes, bits 5:3
  localparam logic [2:0] RETRY_NONE    = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // action byte field positions
  localparam int ACT_RESP_MSB  = 7;
  localparam int ACT_RESP_LSB  = 6;
  localparam int ACT_RETRY_MSB = 5;
  localparam int ACT_RETRY_LSB = 3;
  localparam int ACT_DELAY_MSB = 2;
  localparam int ACT_DELAY_LSB = 0;

  // power-down target is one eighth of the programmed voltage
  localparam int OFF_TARGET_SHIFT = 3;

  // millisecond tick derived from the clock period
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic [1:0] resp;
    logic [2:0] retries;
    logic [2:0] delay;
  } ost_action_type;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] code;
    logic [15:0] wdata;
  } ost_cmd_type;

  typedef enum logic [7:0] {
    ST_OFF      = 8'b0000_0001,
    ST_ON_WAIT  = 8'b0000_0010,
    ST_RISE     = 8'b0000_0100,
    ST_ON       = 8'b0000_1000,
    ST_OFF_WAIT = 8'b0001_0000,
    ST_FALL     = 8'b0010_0000,
    ST_RETRY    = 8'b0100_0000,
    ST_LATCHED  = 8'b1000_0000
  } ost_state_type;

endpackage

// ==== design/ost_sequencer.sv ====
// ost_sequencer: output turn-on/turn-off sequencer with power-good and timeout fault engine.
// assumes measured and programmed voltages share one unsigned encoding, times are plain
// millisecond counts and the fault time unit arrives as a millisecond count.
//
// Contract
// - raise output_good_flag when measured voltage reaches the assert threshold.
// - drop output_good_flag when measured voltage falls to the deassert threshold.
// - after enable, wait turn_on_wait_time milliseconds before ramping up.
// - then ramp up over turn_on_ramp_time milliseconds.
// - timeout fault if output stays below undervoltage limit past power_up_timeout_limit.
// - a zero power_up_timeout_limit disables the timeout.
// - response 00 ignores the fault and keeps running.
// - response 01 runs on for the delay, then shuts down and follows the retry setting if fault persists.
// - response 10 disables at once, then follows the retry setting.
// - response 11 stays off until clear, reset, or off-then-on.
// - retries 000 means no restart; stays off until cleared.
// - retries 1 to 6 allow that many restarts, then latch off.
// - restart attempts spaced by delay count times the fault time unit.
// - retries 111 restart without limit until commanded off.
// - delay field n selects 2^n time units, 1 to 128.
// - time unit comes from the output-voltage fault time unit.
// - after disable, wait turn_off_wait_time milliseconds before ramping down.
// - then ramp down over turn_off_ramp_time milliseconds.
// - warn if output above one eighth of setpoint past power_down_warn_limit.
// - output_off reports whenever the output delivers no power.
module ost_sequencer import ost_pkg::*; #(
  parameter int TICK_CYCLES = MS_CYCLES
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // command port
  input  wire ost_cmd_type cmd,
  output logic [15:0]      rd_data,
  output logic             rd_valid,
  // control and measurement
  input  wire logic        out_enable_req,
  input  wire logic        clear_faults,
  input  wire logic [15:0] vout_meas,
  input  wire logic [15:0] vout_setpoint,
  input  wire logic [15:0] uv_fault_limit,
  input  wire logic [15:0] vout_fault_unit_ms,
  // power stage and status
  output logic             power_stage_enable,
  output logic             ramp_active,
  output logic             ramp_up,
  output logic [15:0]      ramp_time_ms,
  output logic             output_good_flag,
  output logic             timeout_fault,
  output logic             power_down_warn,
  output logic             output_off
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic       rst_meta_n;
  logic       rst_n;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [15:0]    pgood_assert_threshold;
  logic [15:0]    pgood_deassert_threshold;
  logic [15:0]    turn_on_wait_time;
  logic [15:0]    turn_on_ramp_time;
  logic [15:0]    power_up_timeout_limit;
  ost_action_type power_up_timeout_action;
  logic [15:0]    turn_off_wait_time;
  logic [15:0]    turn_off_ramp_time;
  logic [15:0]    power_down_warn_limit;

  function automatic logic hit(input ost_cmd_type c, input logic [7:0] code);
    return c.valid && c.write && (c.code == code);
  endfunction

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pgood_assert_threshold   <= RESET_WORD;
      pgood_deassert_threshold <= RESET_WORD;
      turn_on_wait_time        <= RESET_WORD;
      turn_on_ramp_time        <= RESET_WORD;
      power_up_timeout_limit   <= RESET_WORD;
      power_up_timeout_action  <= RESET_BYTE;
      turn_off_wait_time       <= RESET_WORD;
      turn_off_ramp_time       <= RESET_WORD;
      power_down_warn_limit    <= RESET_WORD;
    end else begin
      if (hit(cmd, CMD_PGOOD_ASSERT))   pgood_assert_threshold   <= cmd.wdata;
      if (hit(cmd, CMD_PGOOD_DEASSERT)) pgood_deassert_threshold <= cmd.wdata;
      if (hit(cmd, CMD_TURN_ON_WAIT))   turn_on_wait_time        <= cmd.wdata;
      if (hit(cmd, CMD_TURN_ON_RAMP))   turn_on_ramp_time        <= cmd.wdata;
      if (hit(cmd, CMD_PWR_UP_LIMIT))   power_up_timeout_limit   <= cmd.wdata;
      if (hit(cmd, CMD_PWR_UP_ACTION))  power_up_timeout_action  <= cmd.wdata[7:0];
      if (hit(cmd, CMD_TURN_OFF_WAIT))  turn_off_wait_time       <= cmd.wdata;
      if (hit(cmd, CMD_TURN_OFF_RAMP))  turn_off_ramp_time       <= cmd.wdata;
      if (hit(cmd, CMD_PWR_DOWN_LIMIT)) power_down_warn_limit    <= cmd.wdata;
    end
  end

  logic [15:0] next_rd_data;
  always_comb begin
    case (cmd.code)
      CMD_PGOOD_ASSERT:   next_rd_data = pgood_assert_threshold;
      CMD_PGOOD_DEASSERT: next_rd_data = pgood_deassert_threshold;
      CMD_TURN_ON_WAIT:   next_rd_data = turn_on_wait_time;
      CMD_TURN_ON_RAMP:   next_rd_data = turn_on_ramp_time;
      CMD_PWR_UP_LIMIT:   next_rd_data = power_up_timeout_limit;
      CMD_PWR_UP_ACTION:  next_rd_data = {8'h00, power_up_timeout_action};
      CMD_TURN_OFF_WAIT:  next_rd_data = turn_off_wait_time;
      CMD_TURN_OFF_RAMP:  next_rd_data = turn_off_ramp_time;
      CMD_PWR_DOWN_LIMIT: next_rd_data = power_down_warn_limit;
      default:            next_rd_data = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data  <= 16'h0000;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= cmd.valid && !cmd.write;
      if (cmd.valid && !cmd.write) rd_data <= next_rd_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decoding
  ost_state_type state;
  ost_state_type next_state;
  logic [15:0]   phase_ms;
  logic [15:0]   ton_ms;
  logic [15:0]   toff_ms;
  logic [23:0]   grace_ms;
  logic          grace_run;
  logic          above_uv;
  logic [2:0]    attempts;
  logic          en_q;
  logic          ton_seen;

  wire [23:0] unit_span    = 24'(vout_fault_unit_ms) << power_up_timeout_action.delay;
  wire        running      = (state == ST_ON_WAIT) || (state == ST_RISE) || (state == ST_ON);
  wire        below_uv     = vout_meas <= uv_fault_limit;
  wire        ton_expired  = (power_up_timeout_limit != 16'h0000)
                             && (ton_ms >= power_up_timeout_limit);
  wire        ton_event    = running && !above_uv && below_uv && ton_expired
                             && !ton_seen;
  wire        grace_done   = grace_run && (grace_ms >= unit_span) && below_uv;
  wire        do_shutdown  = (ton_event && (power_up_timeout_action.resp != RESP_IGNORE)
                             && (power_up_timeout_action.resp != RESP_DELAYED))
                             || grace_done;
  wire        latch_now    = (power_up_timeout_action.resp == RESP_LATCH)
                             || (power_up_timeout_action.retries == RETRY_NONE)
                             || ((power_up_timeout_action.retries != RETRY_FOREVER)
                                 && (attempts >= power_up_timeout_action.retries));
  // where a shutdown lands: latched off or a timed restart
  ost_state_type fault_next;
  assign fault_next = latch_now ? ST_LATCHED : ST_RETRY;
  wire        off_then_on  = out_enable_req && !en_q;
  wire        phase_done   = phase_ms >= ramp_time_ms;
  wire [15:0] off_target   = vout_setpoint >> OFF_TARGET_SHIFT;
  wire        toff_expired = (power_down_warn_limit != 16'h0000)
                             && (toff_ms >= power_down_warn_limit);

  ////////////////////////////////////////////////////////////////////////////
  // sequencing state machine
  always_comb begin
    next_state = state;
    case (state)
      ST_OFF:      if (out_enable_req) next_state = ST_ON_WAIT;
      // nothing ramped yet, so an early drop skips the turn-off sequence
      ST_ON_WAIT:  if (!out_enable_req) next_state = ST_OFF;
                   else if (do_shutdown) next_state = fault_next;
                   else if (phase_ms >= turn_on_wait_time) next_state = ST_RISE;
      ST_RISE:     if (!out_enable_req) next_state = ST_OFF_WAIT;
                   else if (do_shutdown) next_state = fault_next;
                   else if (phase_done) next_state = ST_ON;
      ST_ON:       if (!out_enable_req) next_state = ST_OFF_WAIT;
                   else if (do_shutdown) next_state = fault_next;
      ST_OFF_WAIT: if (phase_ms >= turn_off_wait_time) next_state = ST_FALL;
      ST_FALL:     if (phase_done) next_state = ST_OFF;
      ST_RETRY:    if (!out_enable_req) next_state = ST_OFF;
                   else if ({8'h00, phase_ms} >= unit_span) next_state = ST_ON_WAIT;
      ST_LATCHED:  if (clear_faults || off_then_on) next_state = ST_ON_WAIT;
                   else if (!out_enable_req) next_state = ST_OFF;
      default:     next_state = ST_OFF;
    endcase
  end

  wire phase_restart = (next_state != state);

  ////////////////////////////////////////////////////////////////////////////
  // millisecond tick, restarted with each phase so that no phase is cut short
  logic [31:0] tick_cnt;
  wire         ms_tick = (tick_cnt == 32'(TICK_CYCLES - 1));
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)                        tick_cnt <= 32'h0000_0000;
    else if (ms_tick || phase_restart) tick_cnt <= 32'h0000_0000;
    else                               tick_cnt <= tick_cnt + 32'h0000_0001;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= ST_OFF;
      phase_ms <= 16'h0000;
      en_q     <= 1'b0;
    end else begin
      state    <= next_state;
      en_q     <= out_enable_req;
      if (phase_restart) phase_ms <= 16'h0000;
      else if (ms_tick && (phase_ms != 16'hFFFF)) phase_ms <= phase_ms + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timeout, grace and retry bookkeeping
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ton_ms    <= 16'h0000;
      ton_seen  <= 1'b0;
      above_uv  <= 1'b0;
      grace_run <= 1'b0;
      grace_ms  <= 24'h00_0000;
      attempts  <= 3'h0;
    end else begin
      if (!running) ton_ms <= 16'h0000;
      else if (ms_tick && (ton_ms != 16'hFFFF)) ton_ms <= ton_ms + 16'h0001;
      if (!running) above_uv <= 1'b0;
      else if (!below_uv) above_uv <= 1'b1;
      // one timeout event per attempt; the sticky flag would mask later attempts
      if (!running) ton_seen <= 1'b0;
      else if (ton_event) ton_seen <= 1'b1;
      // grace period of the keep-operating response
      if (ton_event && (power_up_timeout_action.resp == RESP_DELAYED)) begin
        grace_run <= 1'b1;
        grace_ms  <= 24'h00_0000;
      end else if (!running || grace_done || !below_uv) begin
        grace_run <= 1'b0;
      end else if (grace_run && ms_tick) begin
        grace_ms  <= grace_ms + 24'h00_0001;
      end
      // restart count, frozen at seven for the endless setting
      if ((state == ST_OFF) || (state == ST_LATCHED)) attempts <= 3'h0;
      else if ((state == ST_RETRY) && (next_state == ST_ON_WAIT)
               && (attempts != RETRY_FOREVER)) attempts <= attempts + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-down timer, counting in the turn-off wait, fall and off states only
  wire off_side = (state == ST_OFF_WAIT) || (state == ST_FALL) || (state == ST_OFF);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      toff_ms <= 16'h0000;
    end else if (!off_side) begin
      toff_ms <= 16'h0000;
    end else if (ms_tick && (toff_ms != 16'hFFFF)) begin
      toff_ms <= toff_ms + 16'h0001;
    end
  end

  // states in which the power stage is driven
  function automatic logic drives_stage(input ost_state_type s);
    return (s == ST_RISE) || (s == ST_ON) || (s == ST_OFF_WAIT) || (s == ST_FALL);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // status and power stage drive
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_stage_enable <= 1'b0;
      ramp_active        <= 1'b0;
      ramp_up            <= 1'b0;
      ramp_time_ms       <= 16'h0000;
      output_good_flag   <= 1'b0;
      timeout_fault      <= 1'b0;
      power_down_warn    <= 1'b0;
      output_off         <= 1'b1;
    end else begin
      power_stage_enable <= drives_stage(next_state);
      output_off         <= !drives_stage(next_state);
      ramp_active        <= (next_state == ST_RISE) || (next_state == ST_FALL);
      ramp_up            <= (next_state == ST_RISE);
      ramp_time_ms       <= (next_state == ST_FALL) ? turn_off_ramp_time : turn_on_ramp_time;
      if (vout_meas >= pgood_assert_threshold) output_good_flag <= 1'b1;
      else if (vout_meas <= pgood_deassert_threshold) output_good_flag <= 1'b0;
      if (ton_event) timeout_fault <= 1'b1;
      else if (clear_faults || off_then_on) timeout_fault <= 1'b0;
      if (!running && toff_expired && (vout_meas > off_target)) power_down_warn <= 1'b1;
      else if (clear_faults) power_down_warn <= 1'b0;
    end
  end

endmodule

// ==== test/ost_sequencer_asserts.sv ====
// ost_sequencer_asserts: port-level checks of the output sequencer.
// assumes it is bound into ost_sequencer and sees only its ports.
module ost_sequencer_asserts import ost_pkg::*; #(
  parameter int TICK_CYCLES = MS_CYCLES
) (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        reset_n,
  // command and control
  input wire ost_cmd_type cmd,
  input wire logic        out_enable_req,
  input wire logic [15:0] vout_meas,
  // power stage and status
  input wire logic        power_stage_enable,
  input wire logic        ramp_active,
  input wire logic        ramp_up,
  input wire logic        output_good_flag,
  input wire logic        timeout_fault,
  input wire logic        power_down_warn,
  input wire logic        output_off
);
  logic [15:0] on_thr;
  logic [15:0] off_thr;
  logic [15:0] on_wait;
  logic [15:0] limit;
  logic [7:0]  act;
  //////////////////////////////////////////////////////////////////////////////
  // shadow copies of the programmed words
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      on_thr  <= 16'h0000;
      off_thr <= 16'h0000;
      on_wait <= 16'h0000;
      limit   <= 16'h0000;
      act     <= 8'h00;
    end else if (cmd.valid && cmd.write) begin
      if (cmd.code == CMD_PGOOD_ASSERT) on_thr <= cmd.wdata;
      if (cmd.code == CMD_PGOOD_DEASSERT) off_thr <= cmd.wdata;
      if (cmd.code == CMD_TURN_ON_WAIT) on_wait <= cmd.wdata;
      if (cmd.code == CMD_PWR_UP_LIMIT) limit <= cmd.wdata;
      if (cmd.code == CMD_PWR_UP_ACTION) act <= cmd.wdata[7:0];
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_good_assert: assert property (
    (vout_meas >= on_thr && vout_meas > off_thr) [*2] |-> output_good_flag)
    else $error("power good low above assert threshold");
  a_good_deassert: assert property (
    (vout_meas <= off_thr && vout_meas < on_thr) [*2] |-> !output_good_flag)
    else $error("power good high below deassert threshold");
  a_wait_first: assert property (
    $rose(out_enable_req) && output_off && on_wait != 16'h0000 |=> !power_stage_enable [*4])
    else $error("stage driven before turn-on wait");
  a_stage_needs_req: assert property (
    $rose(power_stage_enable) |-> out_enable_req)
    else $error("stage started without enable request");
  a_ramp_dir: assert property (
    ramp_up |-> ramp_active && power_stage_enable)
    else $error("rising ramp without active stage");
  a_limit_zero: assert property (
    limit == 16'h0000 |-> !$rose(timeout_fault))
    else $error("timeout raised with zero limit");
  a_ignore_runs: assert property (
    $rose(timeout_fault) && act[7:6] == RESP_IGNORE && power_stage_enable && out_enable_req
    |=> power_stage_enable [*8])
    else $error("ignored fault stopped the stage");
  a_disable_now: assert property (
    $rose(timeout_fault) && act[7:6] == RESP_DISABLE |-> ##[0:2] !power_stage_enable)
    else $error("stage not disabled on fault");
  a_latch_off: assert property (
    $rose(timeout_fault) && act[7:6] == RESP_LATCH && out_enable_req
    |-> ##2 !power_stage_enable [*8])
    else $error("latched fault did not hold stage off");
  a_off_exclusive: assert property (
    output_off |-> !power_stage_enable && !ramp_active)
    else $error("off flag while output driven");
  c_fault: cover property ($rose(timeout_fault));
  c_good: cover property ($rose(output_good_flag));
  c_warn: cover property ($rose(power_down_warn));
endmodule

bind ost_sequencer ost_sequencer_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.core_clk,
  .reset_n, .cmd, .out_enable_req, .vout_meas, .power_stage_enable, .ramp_active, .ramp_up,
  .output_good_flag, .timeout_fault, .power_down_warn, .output_off);

// ==== test/ost_plant_model.sv ====
// ost_plant_model: behavioural power stage feeding the measured output voltage.
// assumes the bench decides whether the stage can reach its target.
module ost_plant_model (
  // clock
  input wire logic        core_clk,
  // stage control
  input wire logic        power_stage_enable,
  input wire logic        healthy,
  input wire logic [15:0] target,
  // measurement
  output logic [15:0]     vout_meas
);
  timeunit 1ns;
  timeprecision 1ps;
  initial vout_meas = 16'h0000;
  // output collapses as soon as the stage stops driving
  always @(posedge core_clk) vout_meas <= (power_stage_enable && healthy) ? target : 16'h0000;
endmodule

// ==== test/output_sequencing_fault_retry_tb.sv ====
// output_sequencing_fault_retry_tb: directed tests of the output sequencer.
// assumes a 4-cycle millisecond tick and the plant model on the stage side.
module output_sequencing_fault_retry_tb import ost_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 4;
  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        out_enable_req = 1'b0;
  logic        clear_faults = 1'b0;
  logic        healthy = 1'b1;
  logic [15:0] vout_setpoint = 16'h1800;
  logic [15:0] uv_fault_limit = 16'h0400;
  logic [15:0] vout_fault_unit_ms = 16'h0001;
  logic [15:0] cfg [9] = '{16'h1000, 16'h0800, 16'h0002, 16'h0003, 16'h0000, 16'h0000,
                           16'h0001, 16'h0002, 16'h0001};
  ost_cmd_type cmd = '0;
  logic [15:0] vout_meas, rd_data, ramp_time_ms;
  logic        rd_valid, power_stage_enable, ramp_active, ramp_up;
  logic        output_good_flag, timeout_fault, power_down_warn, output_off;
  int          bad_count = 0;
  int          compares = 0;
  int          n;
  always #4 core_clk = ~core_clk;
  ost_sequencer #(.TICK_CYCLES(TICK)) dut (.core_clk, .reset_n, .cmd, .rd_data, .rd_valid,
    .out_enable_req, .clear_faults, .vout_meas, .vout_setpoint, .uv_fault_limit,
    .vout_fault_unit_ms, .power_stage_enable, .ramp_active, .ramp_up, .ramp_time_ms,
    .output_good_flag, .timeout_fault, .power_down_warn, .output_off);
  ost_plant_model plant (.core_clk, .power_stage_enable, .healthy, .target(vout_setpoint),
    .vout_meas);
  //////////////////////////////////////////////////////////////////////////////
  task results;
    if (bad_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask
  task cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask
  task wr(input logic [7:0] code, input logic [15:0] data);
    @(negedge core_clk) cmd = {1'b1, 1'b1, code, data};
    @(negedge core_clk) cmd.valid = 1'b0;
  endtask
  task rd(input logic [7:0] code, input logic [15:0] exp);
    @(negedge core_clk) cmd = {1'b1, 1'b0, code, 16'h0000};
    @(negedge core_clk) cmd.valid = 1'b0;
    if (rd_valid !== 1'b1) @(negedge core_clk);
    chk("rd_valid", 16'h0001, {15'h0000, rd_valid});
    chk("rd_data", exp, rd_data);
  endtask
  // counts cycles until stage (0) or ramp (1) reaches a level
  task span(input int w, input logic lvl);
    n = 0;
    while ((w == 0 ? power_stage_enable : ramp_active) !== lvl && n < 2000) begin
      cyc(1);
      n++;
    end
  endtask
  task in_range(input string name, input int lo);
    chk(name, 16'h0001, {15'h0000, n >= lo - 1 && n <= lo + 4});
  endtask
  // one turn-on with a dead output, counting stage starts
  task automatic run(input logic [7:0] act, input logic [15:0] unit, input int rises,
                     input int stage, input logic fault, input int gap);
    int   r;
    int   tf;
    int   g;
    logic p;
    r = 0;
    tf = -1;
    g = 0;
    p = 1'b0;
    wr(CMD_PWR_UP_ACTION, {8'h00, act});
    vout_fault_unit_ms = unit;
    out_enable_req = 1'b1;
    cyc(2);
    chk("fault cleared", 16'h0000, {15'h0000, timeout_fault});
    for (int t = 0; t < 400; t++) begin
      cyc(1);
      if (power_stage_enable === 1'b1 && p === 1'b0 && r == 1) g = t - tf;
      if (power_stage_enable === 1'b1 && p === 1'b0) r++;
      if (power_stage_enable === 1'b0 && p === 1'b1 && tf < 0) tf = t;
      p = power_stage_enable;
    end
    chk("restarts", rises[15:0], (r > 9) ? 16'h0009 : r[15:0]);
    if (stage < 2) chk("stage", stage[15:0], {15'h0000, power_stage_enable});
    chk("fault", {15'h0000, fault}, {15'h0000, timeout_fault});
    n = g;
    if (gap > 0) in_range("restart gap", gap);
    out_enable_req = 1'b0;
    cyc(60);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(5);
    reset_n = 1'b1;
    cyc(3);
    for (int i = 0; i < 9; i++) rd(CMD_PGOOD_ASSERT + 8'(i), 16'h0000);
    for (int i = 0; i < 9; i++) wr(CMD_PGOOD_ASSERT + 8'(i), 16'hA5C0 + 16'(i));
    for (int i = 0; i < 9; i++) rd(CMD_PGOOD_ASSERT + 8'(i), i == 5 ? 16'h00C5 : 16'hA5C0 + 16'(i));
    wr(8'h67, 16'hFFFF);
    rd(8'h67, 16'h0000);
    for (int i = 0; i < 9; i++) wr(CMD_PGOOD_ASSERT + 8'(i), cfg[i]);
    out_enable_req = 1'b1;
    span(0, 1'b1);
    in_range("turn-on wait", 2 * TICK);
    chk("ramp up", 16'h0001, {15'h0000, ramp_up});
    chk("rise time", 16'h0003, ramp_time_ms);
    span(1, 1'b0);
    in_range("rise length", 3 * TICK);
    chk("good on", 16'h0001, {15'h0000, output_good_flag});
    chk("off low", 16'h0000, {15'h0000, output_off});
    out_enable_req = 1'b0;
    span(1, 1'b1);
    in_range("turn-off wait", TICK);
    chk("ramp down", 16'h0000, {15'h0000, ramp_up});
    chk("fall time", 16'h0002, ramp_time_ms);
    span(0, 1'b0);
    in_range("fall length", 2 * TICK);
    cyc(20);
    chk("off high", 16'h0001, {15'h0000, output_off});
    chk("good off", 16'h0000, {15'h0000, output_good_flag});
    chk("warn", 16'h0001, {15'h0000, power_down_warn});
    chk("stays off", 16'h0000, {15'h0000, power_stage_enable});
    clear_faults = 1'b1;
    cyc(1);
    clear_faults = 1'b0;
    cyc(1);
    chk("warn cleared", 16'h0000, {15'h0000, power_down_warn});
    wr(CMD_TURN_ON_WAIT, 16'h0001);
    wr(CMD_TURN_ON_RAMP, 16'h0001);
    wr(CMD_PWR_UP_LIMIT, 16'h0002);
    healthy = 1'b0;
    run(8'h00, 16'h0001, 1, 1, 1'b1, 0);
    run(8'hD0, 16'h0001, 1, 0, 1'b1, 0);
    run(8'h80, 16'h0001, 1, 0, 1'b1, 0);
    run(8'h91, 16'h0002, 3, 0, 1'b1, 5 * TICK);
    run(8'h48, 16'h0001, 2, 0, 1'b1, 0);
    run(8'hB8, 16'h0001, 9, 2, 1'b1, 0);
    wr(CMD_PWR_UP_LIMIT, 16'h0000);
    run(8'h80, 16'h0001, 1, 1, 1'b0, 0);
    results;
  end
  initial begin
    #200000;
    bad_count++;
    results;
  end
endmodule
